// ---- hw/tccc_core.sv ----
// Function
// R1: Fast bit clear: normal compare, 5-cycle trigger.
// R2: Fast bit: trigger forces compare level, 3 cycles; here 4 cycles from internal_trigger_source to channel_out.
// R3: Fast bit matters only in PWM modes.
// R4: Channel 1 select: out, input1, input2, trigger.
// R5: Software selects trigger only with slave trigger set.
// R6: Direction select writable only while channel disabled.
// R7: Channel 2 select: 01 input2, 10 input1.
// R8: Channel 3 select: 01 input3, 10 input4.
// R9: Channel 4 select: 01 input4, 10 input3.
// R10: Filter needs N agreeing samples per transition.
// R11: Codes 0-3: unfiltered, or kernel rate N 2/4/8; code 0 here samples only on the dead-time tick.
// R12: Codes 4-15: dead-time clock divided, table N.
// R13: Prescaler captures every 1st/2nd/4th/8th event.
// R14: Prescaler counter cleared while channel disabled.
// R15: Software keeps complementary polarity zero for outputs.
// R16: Output polarity 0 active high, 1 low.
// R17: Input polarity pair picks rising/falling/both edges.
// R18: Software never programs polarity pair 10.
// R19: Output enable gates the pin drive.
// R20: Input enable gates capture into capture register.
// R21: Enable register uses 4-bit group per channel.
// R22: Mode register holds two 8-bit channel slices.
// R23: Capture copies counter and sets capture flag.
// R24: Disabled output drives pin and enable low.
// R25: All channels share channel 1 semantics.
//
// Decided for this implementation: register access over AHB-Lite.
module tccc_core #(
    parameter int DTS_DIV = 1
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [3:0] timer_input_pin,
    input wire logic internal_trigger_source,
    input wire logic [3:0] compare_ref,
    input wire logic [tccc_pkg::TCCC_CNT_W-1:0] counter_value,
    output logic [3:0] channel_out,
    output logic [3:0] output_drive_enable,
    output logic [3:0] capture_pulse
);
    import tccc_pkg::*;

    initial begin
        if (DTS_DIV < 1 || DTS_DIV > 256) begin
            $error("DTS_DIV out of range");
        end
    end

    // ==========================================
    // AHB-Lite slave
    logic [15:0] mode12_q, mode34_q, enpol_q, ctrl_q;
    logic [3:0] flag_q;
    logic [TCCC_CNT_W-1:0] capt_q [4];
    logic wr_pend_q;
    logic [7:0] wr_addr_q;
    logic [31:0] rdata_q;
    wire addr_ok = hsel && hready && htrans[1];
    wire do_wr = addr_ok && hwrite;
    wire do_rd = addr_ok && !hwrite;
    wire [31:0] wdat = hwdata;
    wire wr_m12 = wr_pend_q && wr_addr_q == TCCC_MODE12_OFS;
    wire wr_m34 = wr_pend_q && wr_addr_q == TCCC_MODE34_OFS;
    wire wr_enp = wr_pend_q && wr_addr_q == TCCC_ENPOL_OFS;
    wire wr_flg = wr_pend_q && wr_addr_q == TCCC_FLAGS_OFS;
    wire wr_ctl = wr_pend_q && wr_addr_q == TCCC_CTRL_OFS;
    wire [1:0] capt_idx = 2'((haddr - TCCC_CAPT1_OFS) >> 2);
    wire capt_hit = haddr >= TCCC_CAPT1_OFS && haddr < TCCC_CAPT1_OFS + 8'h10
        && haddr[1:0] == 2'h0;
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (haddr == TCCC_MODE12_OFS) rd_mux = {16'h0000, mode12_q};
        if (haddr == TCCC_MODE34_OFS) rd_mux = {16'h0000, mode34_q};
        if (haddr == TCCC_ENPOL_OFS) rd_mux = {16'h0000, enpol_q};
        if (haddr == TCCC_FLAGS_OFS) rd_mux = {28'h0000000, flag_q};
        if (haddr == TCCC_CTRL_OFS) rd_mux = {16'h0000, ctrl_q};
        if (capt_hit) rd_mux = {16'h0000, capt_q[capt_idx]};
    end
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rdata_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            rdata_q <= 32'h0000_0000;
        end else begin
            wr_pend_q <= do_wr;
            if (addr_ok) wr_addr_q <= haddr;
            if (do_rd) rdata_q <= rd_mux;
        end
    end

    // Direction select fields only change while their channel is off.
    logic [15:0] m12_d, m34_d;
    always_comb begin
        m12_d = mode12_q;
        m34_d = mode34_q;
        if (wr_m12) begin
            m12_d = {wdat[15:10], enpol_q[4] ? mode12_q[9:8] : wdat[9:8], // R6
                     wdat[7:2], enpol_q[0] ? mode12_q[1:0] : wdat[1:0]}; // R6
        end
        if (wr_m34) begin
            m34_d = {wdat[15:10], enpol_q[12] ? mode34_q[9:8] : wdat[9:8], // R6
                     wdat[7:2], enpol_q[8] ? mode34_q[1:0] : wdat[1:0]}; // R6
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode12_q <= TCCC_MODE_RST;
            mode34_q <= TCCC_MODE_RST;
            enpol_q <= TCCC_ENPOL_RST;
            ctrl_q <= 16'h0000;
        end else begin
            mode12_q <= m12_d; // R22
            mode34_q <= m34_d; // R22
            if (wr_enp) enpol_q <= wdat[15:0] & TCCC_ENPOL_WMASK; // R21
            if (wr_ctl) ctrl_q <= {12'h000, wdat[3:0]};
        end
    end

    // ==========================================
    // Dead-time clock enable divider
    logic [7:0] dts_cnt_q;
    logic [4:0] dts_sub_q;
    wire dts_tick = dts_cnt_q == 8'(DTS_DIV - 1);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dts_cnt_q <= 8'h00;
            dts_sub_q <= 5'h00;
        end else if (dts_tick) begin
            dts_cnt_q <= 8'h00;
            dts_sub_q <= dts_sub_q + 5'h01;
        end else begin
            dts_cnt_q <= dts_cnt_q + 8'h01;
        end
    end

    // Two-flop synchronisers on the pins and the trigger.
    logic [4:0] sync1_q, sync2_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1_q <= 5'h00;
            sync2_q <= 5'h00;
        end else begin
            sync1_q <= {internal_trigger_source, timer_input_pin};
            sync2_q <= sync1_q;
        end
    end

    // ==========================================
    // Trigger edge delay lines for the compare output path
    logic trig_prev_q;
    logic [TCCC_TRIG_SLOW_CYC-1:0] trig_pipe_q;
    wire trig_edge = sync2_q[4] && !trig_prev_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            trig_prev_q <= 1'b0;
            trig_pipe_q <= '0;
        end else begin
            trig_prev_q <= sync2_q[4];
            trig_pipe_q <= {trig_pipe_q[TCCC_TRIG_SLOW_CYC-2:0], trig_edge};
        end
    end
    // Edge reaches the output after the two sync flops, this tap and the output flop.
    wire trig_fast = trig_pipe_q[TCCC_TRIG_FAST_CYC-3]; // R2

    logic [3:0] flag_set;
    genvar ch;
    generate
        for (ch = 0; ch < 4; ch++) begin : g_ch
            localparam int MB = (ch % 2) * 8;
            localparam int EB = ch * 4;
            wire [15:0] mreg = (ch < 2) ? mode12_q : mode34_q;
            wire [7:0] slice = mreg[MB +: 8];
            wire [1:0] dsel = slice[TCCC_SEL_LSB +: 2];
            wire [3:0] fcode = slice[TCCC_FILT_LSB +: 4];
            wire [1:0] psc = slice[TCCC_PSC_LSB +: 2];
            wire [2:0] omode = slice[TCCC_OMODE_LSB +: 3];
            wire fast_trigger_enable = slice[TCCC_FAST_BIT];
            wire enable = enpol_q[EB + TCCC_EN_BIT];
            wire pol = enpol_q[EB + TCCC_POL_BIT];
            wire npol = enpol_q[EB + TCCC_NPOL_BIT];
            // Direct and crossed neighbour pins per channel.
            localparam int DIR = ch;
            localparam int CRS = ch ^ 1;
            logic raw_in;
            always_comb begin
                unique case (dsel)
                    TCCC_SEL_DIRECT: raw_in = sync2_q[DIR]; // R4 R7 R8 R9
                    TCCC_SEL_CROSS: raw_in = sync2_q[CRS]; // R4 R7 R8 R9
                    TCCC_SEL_TRIG: raw_in = sync2_q[4]; // R4
                    default: raw_in = 1'b0;
                endcase
            end

            // Filter: sample rate and length from the four-bit code.
            logic smp_en;
            logic [3:0] need_n;
            always_comb begin
                smp_en = 1'b1;
                need_n = 4'h1;
                unique case (fcode)
                    4'h0: smp_en = dts_tick; // R11
                    4'h1: need_n = 4'h2; // R11
                    4'h2: need_n = 4'h4;
                    4'h3: need_n = 4'h8;
                    default: begin
                        smp_en = dts_tick && (fcode < 4'h6 ? dts_sub_q[0] == 1'b1 :
                            fcode < 4'h8 ? dts_sub_q[1:0] == 2'h3 :
                            fcode < 4'hA ? dts_sub_q[2:0] == 3'h7 :
                            fcode < 4'hD ? dts_sub_q[3:0] == 4'hF : &dts_sub_q); // R12
                        unique case (fcode)
                            4'h4, 4'h6, 4'h8, 4'hB, 4'hE: need_n = 4'h6; // R12
                            4'hA, 4'hD: need_n = 4'h5;
                            default: need_n = 4'h8;
                        endcase
                    end
                endcase
            end
            logic filt_q;
            logic [3:0] agree_q;
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    filt_q <= 1'b0;
                    agree_q <= 4'h0;
                end else if (smp_en) begin
                    if (raw_in == filt_q) begin
                        agree_q <= 4'h0;
                    end else if (agree_q + 4'h1 >= need_n) begin
                        filt_q <= raw_in; // R10
                        agree_q <= 4'h0;
                    end else begin
                        agree_q <= agree_q + 4'h1;
                    end
                end
            end

            // Edge select from the polarity pair.
            logic filt_prev_q;
            wire rise = filt_q && !filt_prev_q;
            wire fall = !filt_q && filt_prev_q;
            wire edge_hit = npol ? (rise || fall) : (pol ? fall : rise); // R17
            wire is_in = dsel != TCCC_SEL_OUT;
            logic [2:0] psc_q;
            wire [2:0] psc_lim = 3'((4'h1 << psc) - 4'h1);
            wire cap_fire = is_in && enable && edge_hit && psc_q == psc_lim; // R13 R20
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    filt_prev_q <= 1'b0;
                    psc_q <= 3'h0;
                    capt_q[ch] <= '0;
                    capture_pulse[ch] <= 1'b0;
                end else begin
                    filt_prev_q <= filt_q;
                    capture_pulse[ch] <= cap_fire;
                    if (!enable) psc_q <= 3'h0; // R14
                    else if (is_in && edge_hit) psc_q <= cap_fire ? 3'h0 : psc_q + 3'h1;
                    if (cap_fire) capt_q[ch] <= counter_value; // R23
                end
            end
            assign flag_set[ch] = cap_fire;

            // Output path with optional fast trigger in PWM modes.
            wire pwm = omode == TCCC_OM_PWM1 || omode == TCCC_OM_PWM2;
            wire fast_on = fast_trigger_enable && pwm; // R3
            wire ref_lvl = fast_on ? (compare_ref[ch] || trig_fast) // R2
                : compare_ref[ch]; // R1
            logic oc_q, oen_q;
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    oc_q <= 1'b0;
                    oen_q <= 1'b0;
                end else if (!is_in && enable) begin
                    oc_q <= ref_lvl ^ pol; // R16 R19
                    oen_q <= 1'b1;
                end else begin
                    oc_q <= 1'b0; // R24
                    oen_q <= 1'b0;
                end
            end
            assign channel_out[ch] = oc_q;
            assign output_drive_enable[ch] = oen_q; // R25
        end
    endgenerate

    // Capture flags: hardware set wins over write-0 clear; reading a
    // capture register clears its flag.
    wire [3:0] rd_clr = (do_rd && capt_hit) ? 4'(4'h1 << capt_idx) : 4'h0;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flag_q <= 4'h0;
        end else begin
            flag_q <= (flag_q & ~(wr_flg ? ~wdat[3:0] : 4'h0) & ~rd_clr) | flag_set; // R23
        end
    end

    // ==========================================
    // Checks
    a_dir_locked: assert property (@(posedge hclk) disable iff (!hresetn) // R6
        enpol_q[0] && $past(enpol_q[0]) |-> $stable(mode12_q[1:0]))
        else $error("direction changed while enabled");
    a_lock_ch4: assert property (@(posedge hclk) disable iff (!hresetn) // R6
        enpol_q[12] && $past(enpol_q[12]) |-> $stable(mode34_q[9:8]))
        else $error("channel 4 direction changed while enabled");
    a_psc_clear: assert property (@(posedge hclk) disable iff (!hresetn) // R14
        !$past(enpol_q[0]) |-> g_ch[0].psc_q == 3'h0)
        else $error("prescaler not cleared");
    a_psc_ch4: assert property (@(posedge hclk) disable iff (!hresetn) // R14 R25
        !$past(enpol_q[12]) |-> g_ch[3].psc_q == 3'h0)
        else $error("channel 4 prescaler not cleared");
    a_capt_copy: assert property (@(posedge hclk) disable iff (!hresetn) // R23
        g_ch[0].cap_fire |=> capt_q[0] == $past(counter_value) && flag_q[0])
        else $error("capture not taken");
    a_read_clear: assert property (@(posedge hclk) disable iff (!hresetn) // R23
        do_rd && capt_hit && capt_idx == 2'h0 && !g_ch[0].cap_fire |=> !flag_q[0])
        else $error("capture read did not clear flag");
    a_off_low: assert property (@(posedge hclk) disable iff (!hresetn) // R24
        !$past(enpol_q[4]) |-> !channel_out[1] && !output_drive_enable[1])
        else $error("disabled output driven");
    a_off_ch3: assert property (@(posedge hclk) disable iff (!hresetn) // R24 R25
        !$past(enpol_q[8]) |-> !channel_out[2] && !output_drive_enable[2])
        else $error("disabled channel 3 output driven");
    a_drive_on: assert property (@(posedge hclk) disable iff (!hresetn) // R19
        $past(enpol_q[0]) && $past(mode12_q[1:0]) == 2'h0 |-> output_drive_enable[0])
        else $error("enabled output not driven");
    a_pol_out: assert property (@(posedge hclk) disable iff (!hresetn) // R16
        $past(enpol_q[0] && mode12_q[1:0] == 2'h0) |->
        channel_out[0] == ($past(compare_ref[0] || (g_ch[0].fast_on && trig_fast))
        ^ $past(enpol_q[1])))
        else $error("output polarity wrong");
    a_no_cap_off: assert property (@(posedge hclk) disable iff (!hresetn) // R20
        !enpol_q[8] |-> !g_ch[2].cap_fire)
        else $error("capture while disabled");
    a_fast_lat: assert property (@(posedge hclk) disable iff (!hresetn) // R2
        $rose(sync2_q[4]) && !trig_prev_q ##1 g_ch[3].fast_on && !compare_ref[3]
        && enpol_q[12] && mode34_q[9:8] == 2'h0 && !enpol_q[13] |=> channel_out[3])
        else $error("fast trigger latency");
    a_slow_ignore: assert property (@(posedge hclk) disable iff (!hresetn) // R1 R3
        !g_ch[2].fast_on && !compare_ref[2] && enpol_q[8] && !enpol_q[9]
        && mode34_q[1:0] == 2'h0 |=> !channel_out[2])
        else $error("trigger leaked without fast enable");
    a_trig_route: assert property (@(posedge hclk) disable iff (!hresetn) // R4
        mode12_q[1:0] == 2'h3 |-> g_ch[0].raw_in == sync2_q[4])
        else $error("channel 1 trigger routing");
    a_cross_ch1: assert property (@(posedge hclk) disable iff (!hresetn) // R4
        mode12_q[1:0] == 2'h2 |-> g_ch[0].raw_in == sync2_q[1])
        else $error("channel 1 routing");
    a_cross_ch2: assert property (@(posedge hclk) disable iff (!hresetn) // R7
        mode12_q[9:8] == 2'h2 |-> g_ch[1].raw_in == sync2_q[0])
        else $error("channel 2 routing");
    a_cross_ch3: assert property (@(posedge hclk) disable iff (!hresetn) // R8
        mode34_q[1:0] == 2'h2 |-> g_ch[2].raw_in == sync2_q[3])
        else $error("channel 3 routing");
    a_sel_cross: assert property (@(posedge hclk) disable iff (!hresetn) // R9
        mode34_q[9:8] == 2'h2 |-> g_ch[3].raw_in == sync2_q[2])
        else $error("channel 4 routing");
    a_direct_ch4: assert property (@(posedge hclk) disable iff (!hresetn) // R9
        mode34_q[9:8] == 2'h1 |-> g_ch[3].raw_in == sync2_q[3])
        else $error("channel 4 direct routing");
    a_resv_zero: assert property (@(posedge hclk) disable iff (!hresetn) // R21
        (enpol_q & ~TCCC_ENPOL_WMASK) == 16'h0000)
        else $error("reserved enable bit set");
    a_filt_len: assert property (@(posedge hclk) disable iff (!hresetn) // R10 R11
        g_ch[0].fcode == 4'h3 && $past(g_ch[0].fcode, 8) == 4'h3 && $changed(g_ch[0].filt_q)
        |-> $past(g_ch[0].raw_in, 8) == g_ch[0].filt_q && $past(g_ch[0].raw_in) == g_ch[0].filt_q)
        else $error("filter accepted too few samples");
endmodule

// ---- common/tccc_pkg.sv ----
package tccc_pkg;
    // ==========================================
    // Register map
    localparam logic [7:0] TCCC_MODE12_OFS = 8'h18;
    localparam logic [7:0] TCCC_MODE34_OFS = 8'h1C;
    localparam logic [7:0] TCCC_ENPOL_OFS = 8'h20;
    localparam logic [7:0] TCCC_CAPT1_OFS = 8'h34;
    localparam logic [7:0] TCCC_FLAGS_OFS = 8'h44;
    localparam logic [7:0] TCCC_CTRL_OFS = 8'h50;
    localparam logic [15:0] TCCC_MODE_RST = 16'h0000;
    localparam logic [15:0] TCCC_ENPOL_RST = 16'h0000;
    localparam logic [15:0] TCCC_ENPOL_WMASK = 16'hBBBB;
    // ==========================================
    // Field positions within one 8-bit channel slice
    localparam int TCCC_SEL_LSB = 0;
    localparam int TCCC_FAST_BIT = 2;
    localparam int TCCC_PSC_LSB = 2;
    localparam int TCCC_OMODE_LSB = 4;
    localparam int TCCC_FILT_LSB = 4;
    // Per-channel group in the enable/polarity register
    localparam int TCCC_EN_BIT = 0;
    localparam int TCCC_POL_BIT = 1;
    localparam int TCCC_NPOL_BIT = 3;
    // ==========================================
    // Direction select and output modes
    localparam logic [1:0] TCCC_SEL_OUT = 2'h0;
    localparam logic [1:0] TCCC_SEL_DIRECT = 2'h1;
    localparam logic [1:0] TCCC_SEL_CROSS = 2'h2;
    localparam logic [1:0] TCCC_SEL_TRIG = 2'h3;
    localparam logic [2:0] TCCC_OM_PWM1 = 3'h6;
    localparam logic [2:0] TCCC_OM_PWM2 = 3'h7;
    // Trigger-to-output latency in kernel cycles.
    localparam int TCCC_TRIG_SLOW_CYC = 5;
    localparam int TCCC_TRIG_FAST_CYC = 3;
    localparam int TCCC_CNT_W = 16;
endpackage

// ---- bench/tccc_pin_model.sv ----
// ==========================================
// Far-side pins: timer inputs, trigger, compare reference and counter.
module tccc_pin_model
    import tccc_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [8:0] req,
    output logic [3:0] timer_input_pin,
    output logic internal_trigger_source,
    output logic [3:0] compare_ref,
    output logic [tccc_pkg::TCCC_CNT_W-1:0] counter_value
);
    timeunit 1ns;
    timeprecision 1ns;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            timer_input_pin <= 4'h0;
            internal_trigger_source <= 1'b0;
            compare_ref <= 4'h0;
            counter_value <= '0;
        end else begin
            {compare_ref, internal_trigger_source, timer_input_pin} <= req;
            counter_value <= counter_value + 1'b1;
        end
    end
endmodule

// ---- bench/test_timer_channel_capture_compare_config.sv ----
`define CHK(nm, e, g) begin \
    check_count++; \
    if ((g) !== (e)) begin \
        miscompares++; \
        $display("Error %s expected %0h seen %0h", nm, e, g); \
    end \
end
module test_timer_channel_capture_compare_config;
    import tccc_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, internal_trigger_source;
    logic [7:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, rd;
    logic [3:0] timer_input_pin, compare_ref, channel_out, output_drive_enable;
    logic [3:0] capture_pulse, e_v;
    logic hit;
    logic [15:0] counter_value;
    logic [8:0] req;
    logic [3:0] exp_q[$];
    logic [7:0] ra[4];
    int miscompares = 0;
    int check_count = 0;
    int cycles = 0;
    int seed, pin, n;
    tccc_core #(.DTS_DIV(1)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .timer_input_pin(timer_input_pin), .internal_trigger_source(internal_trigger_source),
        .compare_ref(compare_ref), .counter_value(counter_value), .channel_out(channel_out),
        .output_drive_enable(output_drive_enable), .capture_pulse(capture_pulse));
    tccc_pin_model pins_u (.hclk(hclk), .hresetn(hresetn), .req(req),
        .timer_input_pin(timer_input_pin), .internal_trigger_source(internal_trigger_source),
        .compare_ref(compare_ref), .counter_value(counter_value));
    initial begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 60000) begin
            miscompares++;
            give_verdict();
        end
    end
    // ==========================================
    // Every capture pulse is matched against the oldest expected channel.
    always @(posedge hclk) begin
        if (hresetn === 1'b1 && capture_pulse !== 4'h0) begin
            e_v = (exp_q.size() == 0) ? 4'h0 : exp_q.pop_front();
            `CHK("capture_pulse", e_v, capture_pulse)
        end
    end
    // ==========================================
    // Bus and pin tasks; each is entered just after a rising edge.
    task automatic cyc(input int k);
        repeat (k) @(posedge hclk);
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= a;
        hsize <= 3'h2;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {d[31:16] ^ 16'($random(seed)), d[15:0]};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask
    task automatic pulse(input int i, input int w);
        req[i] <= 1'b1;
        cyc(w);
        req[i] <= 1'b0;
        cyc(w);
    endtask
    // Raises the trigger and notes whether channel 1 or 4 ever goes high.
    task automatic trig_watch(output logic seen);
        seen = 1'b0;
        req[4] <= 1'b1;
        repeat (10) begin
            cyc(1);
            seen = seen | channel_out[0] | channel_out[3];
        end
        req[4] <= 1'b0;
        cyc(10);
    endtask
    task automatic cfg(input int ch, input logic [7:0] sl, input logic [3:0] grp);
        bus(1'b1, TCCC_ENPOL_OFS, 32'h00000000);
        bus(1'b1, (ch < 2) ? TCCC_MODE12_OFS : TCCC_MODE34_OFS, 32'(sl) << (8 * (ch % 2)));
        bus(1'b1, TCCC_ENPOL_OFS, 32'(grp) << (4 * ch));
    endtask
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        htrans = 2'h0;
        hwrite = 1'b0;
        haddr = 8'h00;
        hsize = 3'h2;
        hwdata = 32'h00000000;
        req = 9'h000;
        seed = 86;
        ra = '{TCCC_MODE12_OFS, TCCC_MODE34_OFS, TCCC_ENPOL_OFS, 8'h10};
        cyc(10);
        hresetn <= 1'b1;
        cyc(1);
        foreach (ra[i]) begin
            bus(1'b0, ra[i], 32'h00000000);
            `CHK("reset_value", 32'h00000000, rd)
        end
        bus(1'b1, TCCC_ENPOL_OFS, 32'h0000FFFF);
        bus(1'b0, TCCC_ENPOL_OFS, 32'h00000000);
        `CHK("enpol_reserved", 32'h0000BBBB, rd)
        bus(1'b1, TCCC_ENPOL_OFS, 32'h00000000);
        bus(1'b1, TCCC_MODE12_OFS, 32'h00000101);
        bus(1'b1, TCCC_ENPOL_OFS, 32'h00000011);
        bus(1'b1, TCCC_MODE12_OFS, 32'h00000A0E);
        bus(1'b0, TCCC_MODE12_OFS, 32'h00000000);
        `CHK("select_locked", 32'h0000090D, rd)
        for (int ch = 0; ch < 4; ch++) begin
            for (int code = 1; code < 4; code++) begin
                // Trigger code is used only with the trigger input provided.
                pin = (code == 3) ? 4 : ((code == 1) ? ch : (ch ^ 1));
                cfg(ch, 8'(code), 4'h1);
                exp_q.push_back(4'h1 << ch);
                pulse(pin, 12);
            end
        end
        `CHK("routing_left", 0, exp_q.size())
        cfg(0, 8'h01, 4'h3);
        exp_q.push_back(4'h1);
        pulse(0, 12);
        cfg(0, 8'h01, 4'hB);
        exp_q.push_back(4'h1);
        exp_q.push_back(4'h1);
        pulse(0, 12);
        for (int p = 1; p < 4; p++) begin
            cfg(0, 8'h01 | 8'(p << 2), 4'h1);
            repeat (8 >> p) exp_q.push_back(4'h1);
            repeat (8) pulse(0, 12);
        end
        cfg(0, 8'h05, 4'h1);
        pulse(0, 12);
        bus(1'b1, TCCC_ENPOL_OFS, 32'h00000000);
        bus(1'b1, TCCC_ENPOL_OFS, 32'h00000001);
        pulse(0, 12);
        exp_q.push_back(4'h1);
        pulse(0, 12);
        cfg(0, 8'h31, 4'h1);
        repeat (4) pulse(0, 1 + ($unsigned($random(seed)) % 6));
        exp_q.push_back(4'h1);
        pulse(0, 24);
        cfg(0, 8'h11, 4'h1);
        pulse(0, 1);
        exp_q.push_back(4'h1);
        pulse(0, 8);
        cfg(0, 8'hF1, 4'h1);
        pulse(0, 150);
        exp_q.push_back(4'h1);
        pulse(0, 600);
        `CHK("captures_left", 0, exp_q.size())
        bus(1'b0, TCCC_FLAGS_OFS, 32'h00000000);
        `CHK("flag_set", 1'b1, rd[0])
        bus(1'b0, TCCC_CAPT1_OFS, 32'h00000000);
        bus(1'b0, TCCC_FLAGS_OFS, 32'h00000000);
        `CHK("flag_clear", 1'b0, rd[0])
        bus(1'b1, TCCC_ENPOL_OFS, 32'h00000000);
        bus(1'b1, TCCC_MODE12_OFS, 32'h00006060);
        bus(1'b1, TCCC_MODE34_OFS, 32'h00006060);
        for (int ch = 0; ch < 4; ch++) begin
            bus(1'b1, TCCC_ENPOL_OFS, 32'h00000000);
            req[8:5] <= 4'hF;
            cyc(4);
            `CHK("drive_off", 1'b0, output_drive_enable[ch])
            `CHK("out_off", 1'b0, channel_out[ch])
            bus(1'b1, TCCC_ENPOL_OFS, 32'h1 << (4 * ch));
            cyc(4);
            `CHK("drive_on", 1'b1, output_drive_enable[ch])
            `CHK("out_high", 1'b1, channel_out[ch])
            bus(1'b1, TCCC_ENPOL_OFS, 32'h3 << (4 * ch));
            cyc(4);
            `CHK("out_inverted", 1'b0, channel_out[ch])
            req[8:5] <= 4'h0;
            cyc(4);
            `CHK("out_follow", 1'b1, channel_out[ch])
        end
        bus(1'b1, TCCC_ENPOL_OFS, 32'h00001001);
        bus(1'b1, TCCC_MODE12_OFS, 32'h00000004);
        trig_watch(hit);
        `CHK("fast_ignored", 1'b0, hit)
        bus(1'b1, TCCC_MODE12_OFS, 32'h00000060);
        trig_watch(hit);
        `CHK("slow_trigger", 1'b0, hit)
        bus(1'b1, TCCC_MODE12_OFS, 32'h00000064);
        bus(1'b1, TCCC_MODE34_OFS, 32'h00007400);
        req[4] <= 1'b1;
        n = 0;
        while (channel_out[0] !== 1'b1 && n < 12) begin
            cyc(1);
            n++;
        end
        `CHK("fast_trigger", 1'b1, channel_out[0])
        `CHK("fast_trigger_ch4", 1'b1, channel_out[3])
        `CHK("fast_latency", TCCC_TRIG_FAST_CYC + 3, n)
        give_verdict();
    end
endmodule
